// file: verilog/pcht_pkg.sv
`default_nettype none
package pcht_pkg;
   // configuration byte offsets
   localparam logic [7:0] CAP_HEAD_OFS      = 8'h34;
   localparam logic [7:0] INT_LINE_OFS      = 8'h3c;
   localparam logic [7:0] INT_PIN_OFS       = 8'h3d;
   localparam logic [7:0] MIN_GRANT_OFS     = 8'h3e;
   localparam logic [7:0] MAX_LATENCY_OFS   = 8'h3f;
   localparam logic [7:0] TRDY_TMO_OFS      = 8'h40;
   localparam logic [7:0] RETRY_TMO_OFS     = 8'h41;
   localparam logic [7:0] USB_RELEASE_OFS   = 8'h60;
   localparam logic [7:0] FRAME_TRIM_OFS    = 8'h61;
   localparam logic [7:0] PORT_WAKE_OFS     = 8'h62;

   // reset and fixed values
   localparam logic [7:0]  CAP_HEAD_RST     = 8'hdc;
   localparam logic [7:0]  CAP_RSVD_MASK    = 8'hfc;
   localparam logic [7:0]  INT_LINE_RST     = 8'h00;
   localparam logic [7:0]  INT_PIN_NONE     = 8'h00;
   localparam logic [7:0]  INT_PIN_A        = 8'h01;
   localparam logic [7:0]  INT_PIN_B        = 8'h02;
   localparam logic [7:0]  INT_PIN_C        = 8'h03;
   localparam logic [7:0]  INT_PIN_D        = 8'h04;
   localparam logic [7:0]  MIN_GRANT_FS     = 8'h01;
   localparam logic [7:0]  MIN_GRANT_HS     = 8'h02;
   localparam logic [7:0]  MAX_LATENCY_FS   = 8'h2a;
   localparam logic [7:0]  MAX_LATENCY_HS   = 8'h10;
   localparam logic [7:0]  TRDY_TMO_RST     = 8'h00;
   localparam logic [7:0]  RETRY_TMO_RST    = 8'h80;
   localparam logic [7:0]  USB_RELEASE_VAL  = 8'h20;
   localparam logic [7:0]  FRAME_TRIM_RST   = 8'h20;
   localparam logic [15:0] PORT_WAKE_RST    = 16'h001f;
   localparam int          CAP_PRESENT_BIT  = 4;

   // timer geometry
   localparam int TMO_WIDTH       = 13;
   localparam int TRDY_LOW_ZEROS  = 5;

   // latency hint unit, expressed in system clocks
   localparam int HINT_UNIT_NS     = 250;
   localparam int SYS_CLK_MHZ      = 200;
   localparam int HINT_UNIT_CYCLES = (HINT_UNIT_NS * SYS_CLK_MHZ) / 1000;
endpackage
`default_nettype wire

// file: verilog/pcht_tmo_if.sv
`default_nettype none
interface pcht_tmo_if #(parameter int WIDTH = 13);
   logic [WIDTH-1:0] limit;
   logic             restart;
   logic             tick;
   logic             expired;

   modport owner (output limit, output restart, output tick, input expired);
   modport timer (input limit, input restart, input tick, output expired);
endinterface
`default_nettype wire

// file: verilog/pcht_timeout.sv
`default_nettype none
module pcht_timeout #(
   parameter int WIDTH = 13
) (
   // clock and reset
   input  wire logic  sys_clk,
   input  wire logic  resetn,
   // control from the owner
   pcht_tmo_if.timer  tmo
);
   logic [WIDTH-1:0] count;
   logic             fired;

   generate
      if (WIDTH < 2) begin : g_bad_width
         $error("pcht_timeout: WIDTH must be at least 2");
      end
   endgenerate

   // saturating count; a limit of zero means the check is off
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else if (tmo.restart) begin
         count <= '0;
      end else if (tmo.tick && count != '1) begin
         count <= count + 1'b1;
      end
   end

   // one pulse per restart, on the tick that passes the limit
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fired <= 1'b0;
      end else if (tmo.restart) begin
         fired <= 1'b0;
      end else if (tmo.expired) begin
         fired <= 1'b1;
      end
   end

   assign tmo.expired = tmo.tick && !tmo.restart && !fired && tmo.limit != '0
                        && (count >= tmo.limit);
endmodule
`default_nettype wire

// file: verilog/pcht_cfg_tail.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Contract
// - capability head byte at 34h reads fixed DCh, read only.
// - capability head valid only while status capability flag is set.
// - two low bits of capability head always read zero.
// - interrupt line byte at 3Ch, read-write, resets 00h, no effect.
// - pin byte codes: 1 A, 2 B, 3 C, 4 D, zero none.
// - interrupt pin byte at 3Dh reads 01h, pin A.
// - grant and latency hints count 250 ns units; zero means none.
// - min grant at 3Eh reads 01h full-speed, 02h high-speed.
// - max latency at 3Fh reads 2Ah full-speed, 10h high-speed.
// - target-ready timeout byte at 40h resets 00h; zero disables check.
// - 13-bit target-ready timer, byte in upper bits, counts bus clocks.
// - target-ready wait beyond limit sets unrecoverable error flag.
// - retry timeout byte at 41h resets 80h; zero disables check.
// - retries beyond retry limit set unrecoverable error flag.
// - high-speed function holds release 60h, frame trim 61h, wake mask 62h.
////////////////////////////////////////////////////////////////////////////////
module pcht_cfg_tail #(
   parameter bit HIGH_SPEED = 1'b1
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // configuration cycle port
   input  wire logic [7:0]  cfg_addr,
   input  wire logic        cfg_rd,
   input  wire logic        cfg_wr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata,
   output logic             cfg_ack,
   // bus-master transaction events
   input  wire logic        mst_txn_start,
   input  wire logic        mst_attempt_start,
   input  wire logic        mst_wait_trdy,
   input  wire logic        mst_retry,
   input  wire logic        mst_data_done,
   // status flags
   input  wire logic        error_flag_clear,
   output logic             unrecoverable_error_flag,
   output logic             capability_list_present,
   // values used by the host controller core
   output logic [7:0]       interrupt_line_route,
   output logic [7:0]       frame_length_trim,
   output logic [15:0]      port_wake_mask
);
   ////////////////////////////////////////////////////////////////////////////
   // types and helpers

   typedef enum logic [1:0] {
      PCHT_IDLE,
      PCHT_WAIT,
      PCHT_STALLED
   } pcht_txn_e;

   localparam int TW = pcht_pkg::TMO_WIDTH;

   localparam logic [7:0] MIN_GRANT_VAL =
      HIGH_SPEED ? pcht_pkg::MIN_GRANT_HS : pcht_pkg::MIN_GRANT_FS;
   localparam logic [7:0] MAX_LATENCY_VAL =
      HIGH_SPEED ? pcht_pkg::MAX_LATENCY_HS : pcht_pkg::MAX_LATENCY_FS;

   // byte lane of an offset within its dword
   function automatic logic [1:0] lane_of(input logic [7:0] ofs);
      lane_of = ofs[1:0];
   endfunction

   // dword index of an offset
   function automatic logic [5:0] dword_of(input logic [7:0] ofs);
      dword_of = ofs[7:2];
   endfunction

   // write hit on one byte of configuration space
   function automatic logic byte_hit(input logic [7:0] ofs,
                                     input logic [7:0] addr,
                                     input logic [3:0] be);
      byte_hit = (dword_of(addr) == dword_of(ofs)) && be[lane_of(ofs)];
   endfunction

   function automatic logic [7:0] lane_data(input logic [31:0] d,
                                            input logic [1:0]  lane);
      lane_data = d[8*lane +: 8];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // read-write registers

   logic [7:0]  target_ready_timeout_byte;
   logic [7:0]  retry_timeout_byte;
   logic [7:0]  interrupt_line_q;
   logic [7:0]  frame_trim_q;
   logic [15:0] port_wake_q;
   logic        hs_write;

   assign hs_write = cfg_wr && HIGH_SPEED;

   // routing byte only stored for software, nothing inside looks at it
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         interrupt_line_q <= pcht_pkg::INT_LINE_RST;
      end else if (cfg_wr && byte_hit(pcht_pkg::INT_LINE_OFS, cfg_addr, cfg_be)) begin
         interrupt_line_q <= lane_data(cfg_wdata, lane_of(pcht_pkg::INT_LINE_OFS));
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         target_ready_timeout_byte <= pcht_pkg::TRDY_TMO_RST;
      end else if (cfg_wr && byte_hit(pcht_pkg::TRDY_TMO_OFS, cfg_addr, cfg_be)) begin
         target_ready_timeout_byte <= lane_data(cfg_wdata, lane_of(pcht_pkg::TRDY_TMO_OFS));
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         retry_timeout_byte <= pcht_pkg::RETRY_TMO_RST;
      end else if (cfg_wr && byte_hit(pcht_pkg::RETRY_TMO_OFS, cfg_addr, cfg_be)) begin
         retry_timeout_byte <= lane_data(cfg_wdata, lane_of(pcht_pkg::RETRY_TMO_OFS));
      end
   end

   // full-speed functions have no such registers; writes there are dropped
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         frame_trim_q <= pcht_pkg::FRAME_TRIM_RST;
      end else if (hs_write && byte_hit(pcht_pkg::FRAME_TRIM_OFS, cfg_addr, cfg_be)) begin
         frame_trim_q <= lane_data(cfg_wdata, lane_of(pcht_pkg::FRAME_TRIM_OFS));
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         port_wake_q <= pcht_pkg::PORT_WAKE_RST;
      end else if (hs_write && dword_of(cfg_addr) == dword_of(pcht_pkg::PORT_WAKE_OFS)) begin
         if (cfg_be[2]) begin
            port_wake_q[7:0] <= cfg_wdata[23:16];
         end
         if (cfg_be[3]) begin
            port_wake_q[15:8] <= cfg_wdata[31:24];
         end
      end
   end

   assign interrupt_line_route    = interrupt_line_q;
   assign frame_length_trim       = frame_trim_q;
   assign port_wake_mask          = port_wake_q;
   // the list always exists here, so the head byte is always meaningful
   assign capability_list_present = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // configuration reads

   logic [31:0] next_cfg_rdata;

   always_comb begin
      next_cfg_rdata = 32'h0000_0000;
      case (dword_of(cfg_addr))
         dword_of(pcht_pkg::CAP_HEAD_OFS): begin
            next_cfg_rdata[7:0] = pcht_pkg::CAP_HEAD_RST & pcht_pkg::CAP_RSVD_MASK;
         end
         dword_of(pcht_pkg::INT_LINE_OFS): begin
            next_cfg_rdata = {MAX_LATENCY_VAL,
                              MIN_GRANT_VAL,
                              pcht_pkg::INT_PIN_A,
                              interrupt_line_q};
         end
         dword_of(pcht_pkg::TRDY_TMO_OFS): begin
            next_cfg_rdata[15:0] = {retry_timeout_byte, target_ready_timeout_byte};
         end
         dword_of(pcht_pkg::USB_RELEASE_OFS): begin
            if (HIGH_SPEED) begin
               next_cfg_rdata = {port_wake_q, frame_trim_q,
                                 pcht_pkg::USB_RELEASE_VAL};
            end
         end
         default: begin
            next_cfg_rdata = 32'h0000_0000;
         end
      endcase
   end

   // answer one cycle after the request; unmapped dwords read zero
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_rdata <= 32'h0000_0000;
      end else if (cfg_rd) begin
         cfg_rdata <= next_cfg_rdata;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_ack <= 1'b0;
      end else begin
         cfg_ack <= cfg_rd || cfg_wr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transaction tracking

   // timer carriers declared ahead of the tracker that reads their expiry
   pcht_tmo_if #(.WIDTH(TW)) trdy_if ();
   pcht_tmo_if #(.WIDTH(TW)) retry_if ();

   generate
      if (TW < 8 + pcht_pkg::TRDY_LOW_ZEROS) begin : g_bad_timer
         $error("pcht_cfg_tail: timer too narrow for the timeout byte");
      end
   endgenerate

   pcht_txn_e txn_state;
   pcht_txn_e next_txn_state;

   always_comb begin
      next_txn_state = txn_state;
      case (txn_state)
         PCHT_IDLE: begin
            if (mst_txn_start || mst_attempt_start) begin
               next_txn_state = PCHT_WAIT;
            end
         end
         PCHT_WAIT: begin
            if (mst_data_done) begin
               next_txn_state = PCHT_IDLE;
            end else if (trdy_if.expired || retry_if.expired) begin
               next_txn_state = PCHT_STALLED;
            end
         end
         PCHT_STALLED: begin
            // stays until the master gives up or completes
            if (mst_data_done || mst_txn_start) begin
               next_txn_state = mst_txn_start ? PCHT_WAIT : PCHT_IDLE;
            end
         end
         default: begin
            next_txn_state = PCHT_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         txn_state <= PCHT_IDLE;
      end else begin
         txn_state <= next_txn_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timeout timers

   // upper eight bits from the byte, low five fixed zero; counts bus clocks
   assign trdy_if.limit   = {target_ready_timeout_byte, {pcht_pkg::TRDY_LOW_ZEROS{1'b0}}};
   assign trdy_if.restart = mst_attempt_start || mst_txn_start || mst_data_done;
   assign trdy_if.tick    = mst_wait_trdy && txn_state != PCHT_IDLE;

   // retry count spans all attempts of one transaction
   assign retry_if.limit   = {{(TW-8){1'b0}}, retry_timeout_byte};
   assign retry_if.restart = mst_txn_start || mst_data_done;
   assign retry_if.tick    = mst_retry && txn_state != PCHT_IDLE;

   pcht_timeout #(.WIDTH(TW)) u_trdy_timer (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .tmo     (trdy_if.timer)
   );

   pcht_timeout #(.WIDTH(TW)) u_retry_timer (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .tmo     (retry_if.timer)
   );

   ////////////////////////////////////////////////////////////////////////////
   // unrecoverable error flag

   // a new expiry in the clearing cycle wins, so no event is lost
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         unrecoverable_error_flag <= 1'b0;
      end else if (trdy_if.expired || retry_if.expired) begin
         unrecoverable_error_flag <= 1'b1;
      end else if (error_flag_clear) begin
         unrecoverable_error_flag <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// file: verification/pcht_cfg_tail_checker.sv
`default_nettype none
module pcht_cfg_tail_checker #(
   parameter bit HIGH_SPEED = 1'b1
) (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        resetn,
   // configuration port
   input wire logic [7:0]  cfg_addr,
   input wire logic        cfg_rd,
   input wire logic        cfg_wr,
   input wire logic [3:0]  cfg_be,
   input wire logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic        cfg_ack,
   // events, flags and values
   input wire logic        mst_txn_start,
   input wire logic        mst_attempt_start,
   input wire logic        mst_wait_trdy,
   input wire logic        mst_retry,
   input wire logic        mst_data_done,
   input wire logic        error_flag_clear,
   input wire logic        unrecoverable_error_flag,
   input wire logic        capability_list_present,
   input wire logic [7:0]  interrupt_line_route,
   input wire logic [7:0]  frame_length_trim,
   input wire logic [15:0] port_wake_mask
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   logic rd_cap;
   logic rd_int;
   logic wr_line;
   logic wr_wake;
   assign rd_cap  = cfg_rd && cfg_addr[7:2] == 6'h0d;
   assign rd_int  = cfg_rd && cfg_addr[7:2] == 6'h0f;
   assign wr_line = cfg_wr && cfg_addr[7:2] == 6'h0f && cfg_be[0];
   assign wr_wake = HIGH_SPEED && cfg_wr && cfg_addr[7:2] == 6'h18 && cfg_be[3:2] == 2'b11;
   ////////////////////////////////////////////////////////////
   a_cap_fixed: assert property (rd_cap |=> cfg_ack && cfg_rdata[7:0] == 8'hdc)
      else $error("capability head wrong");
   a_cap_low_zero: assert property (rd_cap |=> cfg_rdata[1:0] == 2'b00)
      else $error("capability head low bits set");
   a_cap_present: assert property (capability_list_present)
      else $error("capability list flag low");
   a_pin_inta: assert property (rd_int |=> cfg_rdata[15:8] == 8'h01)
      else $error("interrupt pin byte wrong");
   a_hint_bytes: assert property (rd_int |=>
      cfg_rdata[31:16] == (HIGH_SPEED ? 16'h1002 : 16'h2a01))
      else $error("grant or latency hint wrong");
   a_line_store: assert property (wr_line |=> interrupt_line_route == $past(cfg_wdata[7:0]))
      else $error("line route not stored");
   a_line_keep: assert property (!wr_line |=> $stable(interrupt_line_route))
      else $error("line route changed unasked");
   a_wake_store: assert property (wr_wake |=> port_wake_mask == $past(cfg_wdata[31:16]))
      else $error("wake mask not stored");
   a_flag_sticky: assert property (unrecoverable_error_flag |=>
      unrecoverable_error_flag || $past(error_flag_clear))
      else $error("error flag dropped");
   // the flag may lag its cause by up to three clocks
   a_flag_cause: assert property ($rose(unrecoverable_error_flag) |->
      $past(mst_wait_trdy) || $past(mst_retry) || $past(mst_wait_trdy, 2)
      || $past(mst_retry, 2) || $past(mst_wait_trdy, 3) || $past(mst_retry, 3))
      else $error("error flag without cause");
   c_flag: cover property ($rose(unrecoverable_error_flag));
   c_line: cover property (wr_line);
   c_cap: cover property (rd_cap);
endmodule
bind pcht_cfg_tail pcht_cfg_tail_checker #(.HIGH_SPEED(HIGH_SPEED)) u_chk (
   .sys_clk, .resetn, .cfg_addr, .cfg_rd, .cfg_wr, .cfg_be, .cfg_wdata, .cfg_rdata,
   .cfg_ack, .mst_txn_start, .mst_attempt_start, .mst_wait_trdy, .mst_retry,
   .mst_data_done, .error_flag_clear, .unrecoverable_error_flag,
   .capability_list_present, .interrupt_line_route, .frame_length_trim, .port_wake_mask);
`default_nettype wire

// file: verification/pcht_host_model.sv
`default_nettype none
module pcht_host_model (
   // clock and answer
   input  wire logic        sys_clk,
   input  wire logic        cfg_ack,
   input  wire logic [31:0] cfg_rdata,
   // configuration request
   output logic [7:0]       cfg_addr,
   output logic             cfg_rd,
   output logic             cfg_wr,
   output logic [3:0]       cfg_be,
   output logic [31:0]      cfg_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      cfg_rd = 1'b0;
      cfg_wr = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end
   ////////////////////////////////////////////////////////////
   // released lines show the inverse, so stale data cannot pass
   task automatic drop();
      cfg_rd = 1'b0;
      cfg_wr = 1'b0;
      cfg_addr = ~cfg_addr;
      cfg_be = ~cfg_be;
      cfg_wdata = ~cfg_wdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      cfg_addr = a;
      cfg_be = b;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      drop();
      // one idle edge so the next call never re-drives a line in this step
      @(posedge sys_clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic k);
      cfg_addr = a;
      cfg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      // ack stands only until the next edge, so take the answer now
      d = cfg_rdata;
      k = cfg_ack;
      drop();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic cap_walk(output logic [7:0] p, output logic k);
      logic [31:0] d;
      rd(8'h34, d, k);
      p = d[7:0] & 8'hfc;
   endtask
endmodule
`default_nettype wire

// file: verification/pcht_cfg_tail_tb_top.sv
`default_nettype none
module pcht_cfg_tail_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk, resetn, error_flag_clear, cfg_rd, cfg_wr, cfg_ack;
   logic        mst_txn_start, mst_attempt_start, mst_wait_trdy, mst_retry, mst_data_done;
   logic        unrecoverable_error_flag, capability_list_present, k;
   logic [7:0]  cfg_addr, interrupt_line_route, frame_length_trim, a, p;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata;
   logic [15:0] port_wake_mask;
   logic [7:0]  m [256];
   logic [7:0]  adr [6] = '{8'h34, 8'h3c, 8'h40, 8'h60, 8'h44, 8'hfc};
   int          bad_count, n_checks, t, r;
   pcht_cfg_tail #(.HIGH_SPEED(1'b1)) uut (.sys_clk, .resetn, .cfg_addr, .cfg_rd, .cfg_wr,
      .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .mst_txn_start, .mst_attempt_start,
      .mst_wait_trdy, .mst_retry, .mst_data_done, .error_flag_clear,
      .unrecoverable_error_flag, .capability_list_present, .interrupt_line_route,
      .frame_length_trim, .port_wake_mask);
   pcht_host_model host (.sys_clk, .cfg_ack, .cfg_rdata, .cfg_addr, .cfg_rd, .cfg_wr,
      .cfg_be, .cfg_wdata);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_val({31'h0, got}, {31'h0, exp});
   endtask
   function automatic logic [31:0] exp_rd(input logic [7:0] x);
      case (x[7:2])
         6'h0d: return 32'h0000_00dc;
         6'h0f: return {16'h1002, 8'h01, m[8'h3c]};
         6'h10: return {16'h0000, m[8'h41], m[8'h40]};
         6'h18: return {m[8'h63], m[8'h62], m[8'h61], 8'h20};
         default: return 32'h0000_0000;
      endcase
   endfunction
   task automatic wr(input logic [7:0] x, input logic [3:0] b, input logic [31:0] d);
      logic [7:0] ba;
      host.wr(x, b, d);
      for (int i = 0; i < 4; i++) begin
         ba = {x[7:2], 2'(i)};
         if (b[i] && ba inside {8'h3c, 8'h40, 8'h41, 8'h61, 8'h62, 8'h63})
            m[ba] = d[8*i +: 8];
      end
   endtask
   task automatic rd_chk(input logic [7:0] x);
      logic [31:0] d;
      host.rd(x, d, k);
      chk_flag(k, 1'b1);
      chk_val(d, exp_rd(x));
   endtask
   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask
   // n must be at least one: a zero count would toggle the strobe twice in one step
   task automatic burst(input bit rty, input int n);
      if (!rty) begin
         mst_wait_trdy = 1'b1;
         repeat (n) step();
         mst_wait_trdy = 1'b0;
      end else begin
         repeat (n) begin
            mst_retry = 1'b1;
            step();
            mst_retry = 1'b0;
            step();
         end
      end
   endtask
   task automatic tmo_run(input bit rty, input int lim, input int n1, input int n2);
      mst_txn_start = 1'b1;
      step();
      mst_txn_start = 1'b0;
      burst(rty, n1);
      mst_txn_start = 1'b1;
      step();
      mst_txn_start = 1'b0;
      burst(rty, n2);
      mst_data_done = 1'b1;
      step();
      mst_data_done = 1'b0;
      repeat (3) step();
      chk_flag(unrecoverable_error_flag, lim != 0 && (n1 > lim || n2 > lim));
      error_flag_clear = 1'b1;
      step();
      error_flag_clear = 1'b0;
      step();
      chk_flag(unrecoverable_error_flag, 1'b0);
   endtask
   initial begin
      #50us;
      bad_count++;
      final_report();
   end
   initial begin
      {resetn, error_flag_clear, mst_txn_start, mst_attempt_start} = 4'h0;
      {mst_wait_trdy, mst_retry, mst_data_done} = 3'h0;
      foreach (m[i]) m[i] = 8'h00;
      m[8'h41] = 8'h80;
      m[8'h61] = 8'h20;
      m[8'h62] = 8'h1f;
      void'($urandom(32'hb19d));
      repeat (6) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      step();
      foreach (adr[i]) rd_chk(adr[i]);
      chk_flag(capability_list_present, 1'b1);
      host.cap_walk(p, k);
      chk_val({24'h0, p}, 32'h0000_00dc);
      wr(8'h3c, 4'b0001, {24'h0, 8'($urandom_range(1, 15))});
      rd_chk(8'h3c);
      tmo_run(1'b0, 0, 40, 1);
      tmo_run(1'b1, 128, 129, 1);
      t = $urandom_range(1, 3);
      r = $urandom_range(1, 4);
      wr(8'h40, 4'b0011, {16'h0000, 8'(r), 8'(t)});
      rd_chk(8'h40);
      tmo_run(1'b0, t * 32, t * 32, t * 32);
      tmo_run(1'b0, t * 32, t * 32 + 1, 1);
      tmo_run(1'b1, r, r, r);
      tmo_run(1'b1, r, 1, r + 1);
      wr(8'h40, 4'b0010, 32'h0000_0000);
      tmo_run(1'b1, 0, 9, 1);
      repeat (24) begin
         a = adr[$urandom_range(0, 5)] | 8'($urandom_range(0, 3));
         wr(a, 4'($urandom), $urandom);
         rd_chk(a);
         chk_val({interrupt_line_route, frame_length_trim, port_wake_mask},
            {m[8'h3c], m[8'h61], m[8'h63], m[8'h62]});
      end
      final_report();
   end
endmodule
`default_nettype wire
